/* File: rtl/hdc_dchan.sv */
// HDLC D-channel controller: registers, framer, deframer and FIFOs
`timescale 1ns/10ps
`include "hdc_cfg.svh"
module hdc_dchan
  import hdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Microprocessor port
  input  wire logic [4:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  // Mode
  input  wire logic       te_mode,
  input  wire logic       collision,
  // D-channel bit slots, one enable pulse per bit
  input  wire logic       bit_en,
  input  wire logic       line_rx_bit,
  input  wire logic       bp_rx_bit,
  output logic            line_tx_bit,
  output logic            bp_tx_bit,
  output logic            irq
);
  typedef struct packed {
    logic [7:0]  link_cfg;
    logic        trans;
    logic        abort_tag;
    logic        packet_end_tag;
    logic        rx_fifo_clear;
    logic        tx_fifo_clear;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_flags;
    logic [7:0]  addr1;
    logic [7:0]  addr2;
    logic [7:0]  rdata;
    logic        irq;
    hdc_tx_e     tx_st;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_bits;
    logic [2:0]  tx_ones;
    logic        tx_last;
    logic        tx_in_frame;
    logic [15:0] tx_crc;
    logic        tx_crc_hi;
    logic        tx_draining;
    logic        line_tx;
    logic        bp_tx;
    logic [7:0]  rx_win;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_bits;
    logic [2:0]  rx_ones;
    logic [4:0]  rx_run;
    logic        rx_hunt;
    logic        rx_in_frame;
    logic [1:0]  rx_nbytes;
    logic [7:0]  rx_held;
    logic        rx_hold_v;
    logic        rx_first;
    logic        rx_reject;
    logic [15:0] rx_crc;
    logic        idle;
  } hdc_s;
  hdc_s        s_q;
  hdc_s        s_d;

  logic        tx_pop;
  logic        tx_in_ready;
  logic        tx_out_valid;
  logic [9:0]  tx_out;
  logic [4:0]  tx_level;
  logic        tx_push;
  logic        rx_push;
  logic [9:0]  rx_in;
  logic        rx_in_ready;
  logic        rx_out_valid;
  logic [9:0]  rx_out;
  logic [4:0]  rx_level;
  logic        rx_pop;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ `HDC_CRC_POLY) : (c >> 1);
  endfunction

  function automatic logic [1:0] fill_code(input logic [4:0] n);
    if (n == 5'h00)
      fill_code = `HDC_FILL_EMPTY;
    else if (n <= `HDC_TX_LOW_LEVEL)
      fill_code = `HDC_FILL_LOW;
    else if (n < 5'(`HDC_FIFO_DEPTH))
      fill_code = `HDC_FILL_HIGH;
    else
      fill_code = `HDC_FILL_FULL;
  endfunction

  // Tx FIFO entry: {abort tag, end tag, byte}
  assign tx_push = cpu_wr && cpu_addr == 5'h00 && tx_in_ready;
  hdc_fifo #(.WIDTH(10), .DEPTH(`HDC_FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (s_q.tx_fifo_clear),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   ({s_q.abort_tag, s_q.packet_end_tag, cpu_wdata}),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out),
    .level     (tx_level)
  );

  // Rx FIFO entry: {position code, byte}
  assign rx_pop = cpu_rd && cpu_addr == 5'h01;
  hdc_fifo #(.WIDTH(10), .DEPTH(`HDC_FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (s_q.rx_fifo_clear),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out),
    .level     (rx_level)
  );

  assign cpu_rdata   = s_q.rdata;
  assign irq         = s_q.irq;
  assign line_tx_bit = s_q.line_tx;
  assign bp_tx_bit   = s_q.bp_tx;

  logic       tx_bit;
  logic       rx_bit;
  logic       stuff;
  logic [7:0] ev;
  logic       win_flag;
  logic       win_abort;
  logic [7:0] fbyte;

  always_comb
  begin
    s_d       = s_q;
    tx_pop    = 1'b0;
    rx_push   = 1'b0;
    rx_in     = '0;
    ev        = '0;
    tx_bit    = 1'b1;
    rx_bit    = 1'b1;
    stuff     = 1'b0;
    win_flag  = 1'b0;
    win_abort = 1'b0;
    fbyte     = s_q.rx_sh;
    // Self-clearing pulses last one cycle, enough for a synchronous flush
    s_d.rx_fifo_clear = 1'b0;
    s_d.tx_fifo_clear = 1'b0;

    // Transmit bit engine
    if (bit_en)
    begin
      stuff = !s_q.trans && s_q.tx_in_frame && s_q.tx_ones == 3'h5;
      if (!s_q.link_cfg[`HDC_B_TX_ON])
      begin
        tx_bit = 1'b1;
        s_d.tx_st = HDC_TX_IDLE;
        s_d.tx_bits = 4'h0;
        s_d.tx_in_frame = 1'b0;
      end
      else if (stuff)
      begin
        tx_bit = 1'b0;
        s_d.tx_ones = 3'h0;
      end
      else
      begin
        if (s_q.tx_bits == 4'h0)
        begin
          // Load next byte
          s_d.tx_bits = 4'h8;
          s_d.tx_in_frame = 1'b0;
          s_d.tx_last = 1'b0;
          case (s_q.tx_st)
            HDC_TX_IDLE:
            begin
              // Opening flag even with ones fill, else the far end never syncs
              s_d.tx_sh = (s_q.link_cfg[`HDC_B_FILL] || (tx_out_valid && !s_q.trans))
                          ? `HDC_FLAG : 8'hFF;
              if (tx_out_valid)
                s_d.tx_st = HDC_TX_DATA;
              s_d.tx_crc = `HDC_CRC_INIT;
              s_d.tx_draining = 1'b0;
              if (s_q.trans && !tx_out_valid)
                s_d.tx_sh = 8'hFF;
            end
            HDC_TX_DATA:
            begin
              if (!tx_out_valid)
              begin
                s_d.tx_sh = 8'h7F;
                s_d.tx_st = HDC_TX_IDLE;
                if (!s_q.trans)
                  ev[`HDC_IRQ_UNDER] = 1'b1;
              end
              else if (tx_out[9] && !s_q.trans)
              begin
                s_d.tx_sh = 8'h7F;
                tx_pop = 1'b1;
                s_d.tx_st = HDC_TX_IDLE;
              end
              else
              begin
                s_d.tx_sh = tx_out[7:0];
                s_d.tx_in_frame = 1'b1;
                s_d.tx_draining = 1'b1;
                tx_pop = 1'b1;
                if (tx_out[8] && !s_q.trans)
                begin
                  s_d.tx_st = HDC_TX_CRC;
                  s_d.tx_crc_hi = 1'b0;
                end
                else if (s_q.trans && tx_level == 5'h01)
                  s_d.tx_st = HDC_TX_IDLE;
              end
            end
            HDC_TX_CRC:
            begin
              s_d.tx_in_frame = 1'b1;
              s_d.tx_sh = s_q.tx_crc_hi ? ~s_q.tx_crc[15:8] : ~s_q.tx_crc[7:0];
              s_d.tx_crc_hi = 1'b1;
              if (s_q.tx_crc_hi)
              begin
                s_d.tx_st = HDC_TX_ABORT;
                s_d.tx_last = 1'b1;
              end
            end
            HDC_TX_ABORT:
            begin
              s_d.tx_sh = `HDC_FLAG;
              s_d.tx_st = HDC_TX_IDLE;
              ev[`HDC_IRQ_TX_EOP] = 1'b1;
            end
            default: s_d.tx_st = HDC_TX_IDLE;
          endcase
          s_d.tx_bits = 4'h8;
        end
        // First bit leaves in the load slot, so a byte takes eight slots
        tx_bit = s_d.tx_sh[0];
        s_d.tx_sh = {1'b1, s_d.tx_sh[7:1]};
        s_d.tx_bits = s_d.tx_bits - 4'h1;
        s_d.tx_ones = tx_bit ? s_q.tx_ones + 3'h1 : 3'h0;
        // CRC covers the data bytes only, never its own bytes
        if (s_d.tx_in_frame && s_d.tx_st != HDC_TX_ABORT
            && !(s_d.tx_st == HDC_TX_CRC && s_d.tx_crc_hi))
          s_d.tx_crc = crc_step(s_d.tx_crc, tx_bit);
      end
      s_d.line_tx = s_q.link_cfg[`HDC_B_TX_PORT] ? tx_bit : 1'b1;
      s_d.bp_tx   = s_q.link_cfg[`HDC_B_TX_PORT] ? 1'b1 : tx_bit;

      // Receive bit engine
      if (s_q.link_cfg[`HDC_B_LOOP])
        rx_bit = tx_bit;
      else
        rx_bit = s_q.link_cfg[`HDC_B_RX_PORT] ? line_rx_bit : bp_rx_bit;
      if (!s_q.link_cfg[`HDC_B_RX_ON])
        rx_bit = 1'b1;
      s_d.rx_win = {rx_bit, s_q.rx_win[7:1]};
      win_flag  = s_d.rx_win == `HDC_FLAG;
      win_abort = s_d.rx_win[7:1] == 7'h7F;
      s_d.rx_run = (rx_bit && s_q.rx_run != `HDC_IDLE_ONES) ? s_q.rx_run + 5'h01 :
                   (rx_bit ? s_q.rx_run : 5'h00);
      s_d.idle = !s_q.trans && s_d.rx_run == `HDC_IDLE_ONES;
      if (s_q.trans)
      begin
        s_d.rx_sh = {rx_bit, s_q.rx_sh[7:1]};
        s_d.rx_bits = s_q.rx_bits + 4'h1;
        if (s_q.rx_bits == 4'h7)
        begin
          s_d.rx_bits = 4'h0;
          rx_in = {`HDC_POS_PACKET, s_d.rx_sh};
          rx_push = 1'b1;
        end
      end
      else if (win_flag)
      begin
        if (s_q.rx_in_frame && s_q.rx_nbytes == 2'h2 && !s_q.rx_reject)
        begin
          ev[`HDC_IRQ_RX_EOP] = 1'b1;
          rx_push = 1'b1;
          rx_in = {(s_q.rx_crc == `HDC_CRC_GOOD) ? `HDC_POS_LAST_OK : `HDC_POS_LAST_BAD,
                   s_q.rx_held};
        end
        s_d.rx_hunt = 1'b0;
        s_d.rx_in_frame = 1'b1;
        s_d.rx_bits = 4'h0;
        s_d.rx_nbytes = 2'h0;
        s_d.rx_first = 1'b1;
        s_d.rx_reject = 1'b0;
        s_d.rx_crc = `HDC_CRC_INIT;
        s_d.rx_ones = 3'h0;
      end
      else if (win_abort && s_q.rx_in_frame)
      begin
        ev[`HDC_IRQ_ABORT] = 1'b1;
        ev[`HDC_IRQ_RX_EOP] = 1'b1;
        if (s_q.rx_nbytes == 2'h2 && !s_q.rx_reject)
        begin
          rx_push = 1'b1;
          rx_in = {`HDC_POS_PACKET, s_q.rx_held};
        end
        s_d.rx_in_frame = 1'b0;
      end
      else if (s_q.rx_in_frame && !s_q.rx_hunt)
      begin
        if (s_q.rx_ones == 3'h5 && !rx_bit)
          s_d.rx_ones = 3'h0;
        else
        begin
          s_d.rx_ones = rx_bit ? s_q.rx_ones + 3'h1 : 3'h0;
          s_d.rx_sh = {rx_bit, s_q.rx_sh[7:1]};
          s_d.rx_bits = s_q.rx_bits + 4'h1;
          if (s_q.rx_bits == 4'h7)
          begin
            fbyte = s_d.rx_sh;
            s_d.rx_bits = 4'h0;
            if (s_q.rx_nbytes == 2'h2)
            begin
              s_d.rx_crc = s_q.rx_crc;
              rx_push = !s_q.rx_reject;
              rx_in = {s_q.rx_first ? `HDC_POS_FIRST : `HDC_POS_PACKET, s_q.rx_held};
              s_d.rx_first = s_q.rx_reject ? s_q.rx_first : 1'b0;
              if (s_q.rx_first && s_q.link_cfg[`HDC_B_FILTER])
                s_d.rx_reject = !((s_q.rx_held[7:2] == s_q.addr1[7:2] || !s_q.addr1[0])
                  && (fbyte[7:1] == s_q.addr2[7:1] || fbyte[7:1] == `HDC_BROADCAST
                      || !s_q.addr2[0]));
            end
            s_d.rx_held = fbyte;
            s_d.rx_nbytes = 2'h2;
          end
          for (int i = 0; i < 1; i++)
            s_d.rx_crc = crc_step(s_q.rx_crc, rx_bit);
        end
      end
      if (rx_push && !rx_in_ready)
      begin
        rx_push = 1'b0;
        ev[`HDC_IRQ_RX_OVF] = 1'b1;
        s_d.rx_hunt = 1'b1;
      end
    end

    if (tx_pop && tx_level == `HDC_TX_LOW_LEVEL + 5'h01 && s_q.tx_draining)
      ev[`HDC_IRQ_TX_LOW] = 1'b1;
    if (rx_push && rx_level == `HDC_RX_FULL_LEVEL - 5'h01)
      ev[`HDC_IRQ_RX_FULL] = 1'b1;
    if (collision && te_mode && s_q.link_cfg[`HDC_B_TX_ON])
      ev[`HDC_IRQ_COLL] = 1'b1;

    // Register writes
    if (cpu_wr)
    begin
      case (cpu_addr)
        `HDC_ADDR_LINK_CFG: s_d.link_cfg = cpu_wdata;
        `HDC_ADDR_FIFO_CMD:
        begin
          s_d.trans = cpu_wdata[`HDC_B_TRANS];
          s_d.abort_tag = cpu_wdata[`HDC_B_ABORT];
          s_d.packet_end_tag = cpu_wdata[`HDC_B_EOP];
          if (cpu_wdata[`HDC_B_RX_CLR])
          begin
            s_d.rx_fifo_clear = 1'b1;
            s_d.rx_hunt = 1'b1;
            s_d.rx_in_frame = 1'b0;
          end
          if (cpu_wdata[`HDC_B_TX_CLR])
            s_d.tx_fifo_clear = 1'b1;
        end
        `HDC_ADDR_IRQ:      s_d.irq_mask = cpu_wdata;
        `HDC_ADDR_ADDR1:    s_d.addr1 = cpu_wdata;
        `HDC_ADDR_ADDR2:    s_d.addr2 = cpu_wdata;
        default: ;
      endcase
      if (tx_push)
      begin
        s_d.abort_tag = 1'b0;
        s_d.packet_end_tag = 1'b0;
      end
    end

    // Register reads; set wins over read-clear
    s_d.rdata = 8'h00;
    if (cpu_rd)
    begin
      case (cpu_addr)
        5'h01:              s_d.rdata = rx_out[7:0];
        `HDC_ADDR_LINK_CFG: s_d.rdata = s_q.link_cfg;
        `HDC_ADDR_FIFO_CMD:
          s_d.rdata = {rx_out_valid ? rx_out[9:8] : `HDC_POS_PACKET,
                       fill_code(rx_level),
                       fill_code(tx_level),
                       s_q.idle,
                       s_q.irq};
        `HDC_ADDR_IRQ:
        begin
          s_d.rdata = s_q.irq_flags;
          s_d.irq_flags = 8'h00;
        end
        `HDC_ADDR_ADDR1:    s_d.rdata = s_q.addr1;
        `HDC_ADDR_ADDR2:    s_d.rdata = s_q.addr2;
        default:            s_d.rdata = 8'h00;
      endcase
    end
    s_d.irq_flags = s_d.irq_flags | ev;
    s_d.irq = |(s_d.irq_flags & s_d.irq_mask
                & {te_mode, 7'h7F});
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.tx_st <= HDC_TX_IDLE;
      s_q.tx_crc <= `HDC_CRC_INIT;
      s_q.rx_crc <= `HDC_CRC_INIT;
      s_q.line_tx <= 1'b1;
      s_q.bp_tx <= 1'b1;
      s_q.rx_win <= 8'hFF;
    end
    else
      s_q <= s_d;
  end
endmodule

/* File: rtl/hdc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
module hdc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 19
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [4:0]       level
);
  typedef struct packed {
    logic [4:0] wp;
    logic [4:0] rp;
    logic [4:0] cnt;
  } hdc_fifo_s;
  hdc_fifo_s  s_q;
  hdc_fifo_s  s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic       push;
  logic       pop;

  assign in_ready  = (s_q.cnt != 5'(DEPTH));
  assign out_valid = (s_q.cnt != 5'h00);
  assign out_data  = mem[s_q.rp];
  assign level     = s_q.cnt;
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_comb
  begin
    s_d = s_q;
    if (push)
      s_d.wp = (s_q.wp == 5'(DEPTH - 1)) ? 5'h00 : s_q.wp + 5'h01;
    if (pop)
      s_d.rp = (s_q.rp == 5'(DEPTH - 1)) ? 5'h00 : s_q.rp + 5'h01;
    s_d.cnt = s_q.cnt + {4'h0, push} - {4'h0, pop};
    if (flush)
      s_d = '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[s_q.wp] <= in_data;
  end
endmodule

/* File: shared/hdc_cfg.svh */
// Register map, field positions and counts of the D-channel controller
`ifndef HDC_CFG_SVH
`define HDC_CFG_SVH
`define HDC_ADDR_W        5
`define HDC_ADDR_LINK_CFG 5'h02
`define HDC_ADDR_FIFO_CMD 5'h03
`define HDC_ADDR_IRQ      5'h04
`define HDC_ADDR_ADDR1    5'h06
`define HDC_ADDR_ADDR2    5'h07
`define HDC_B_TX_ON       7
`define HDC_B_RX_ON       6
`define HDC_B_FILTER      5
`define HDC_B_TX_PORT     4
`define HDC_B_RX_PORT     3
`define HDC_B_FILL        2
`define HDC_B_LOOP        0
`define HDC_B_TRANS       4
`define HDC_B_RX_CLR      3
`define HDC_B_TX_CLR      2
`define HDC_B_ABORT       1
`define HDC_B_EOP         0
`define HDC_IRQ_COLL      7
`define HDC_IRQ_RX_EOP    6
`define HDC_IRQ_TX_EOP    5
`define HDC_IRQ_ABORT     4
`define HDC_IRQ_TX_LOW    3
`define HDC_IRQ_UNDER     2
`define HDC_IRQ_RX_FULL   1
`define HDC_IRQ_RX_OVF    0
`define HDC_FIFO_DEPTH    19
`define HDC_TX_LOW_LEVEL  5'h04
`define HDC_RX_FULL_LEVEL 5'h0F
`define HDC_FLAG          8'h7E
`define HDC_CRC_INIT      16'hFFFF
`define HDC_CRC_POLY      16'h8408
`define HDC_CRC_GOOD      16'hF0B8
`define HDC_BROADCAST     7'h7F
`define HDC_IDLE_ONES     5'h0F
`define HDC_POS_PACKET    2'h0
`define HDC_POS_FIRST     2'h1
`define HDC_POS_LAST_OK   2'h2
`define HDC_POS_LAST_BAD  2'h3
`define HDC_FILL_EMPTY    2'h0
`define HDC_FILL_LOW      2'h1
`define HDC_FILL_HIGH     2'h2
`define HDC_FILL_FULL     2'h3
`endif

/* File: shared/hdc_pkg.sv */
// Types of the D-channel controller
package hdc_pkg;
  typedef enum logic [3:0] {
    HDC_TX_IDLE  = 4'b0001,
    HDC_TX_DATA  = 4'b0010,
    HDC_TX_CRC   = 4'b0100,
    HDC_TX_ABORT = 4'b1000
  } hdc_tx_e;
endpackage

/* File: sim/hdc_dchan_asserts.sv */
// Port assertions of the D-channel controller
`timescale 1ns/10ps
module hdc_dchan_asserts (
  // Watched ports
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [4:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       te_mode,
  input wire logic       bit_en,
  input wire logic       line_tx_bit,
  input wire logic       bp_tx_bit,
  input wire logic       irq
);
  logic [7:0] cfg_q;
  logic [7:0] mask_q;

  // Shadows of the write-side registers; the link config also reads back at the pins, the mask does not
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q  <= 8'h00;
      mask_q <= 8'h00;
    end
    else if (cpu_wr)
    begin
      if (cpu_addr == 5'h02) cfg_q <= cpu_wdata;
      if (cpu_addr == 5'h04) mask_q <= cpu_wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cmd(b);
    cpu_wr && cpu_addr == 5'h03 && cpu_wdata[b];
  endsequence
  sequence s_stat_rd;
    cpu_rd && !cpu_wr && cpu_addr == 5'h03;
  endsequence

  a_tx_off_ones: assert property ($past(bit_en) && !$past(cfg_q[7]) |-> line_tx_bit && bp_tx_bit)
    else $error("transmitter off but a zero went out");
  a_line_unsel: assert property ($past(bit_en) && !$past(cfg_q[4]) |-> line_tx_bit)
    else $error("line port not idle while unselected");
  a_bp_unsel: assert property ($past(bit_en) && $past(cfg_q[4]) |-> bp_tx_bit)
    else $error("backplane port not idle while unselected");
  a_irq_all_masked: assert property ((mask_q == 8'h00) [*2] |-> !irq)
    else $error("interrupt with every source masked");
  a_coll_nt_quiet: assert property ((mask_q == 8'h80 && !te_mode) [*2] |-> !irq)
    else $error("collision interrupt outside TE mode");
  a_cfg_read_back: assert property (cpu_rd && !cpu_wr && cpu_addr == 5'h02 |=>
    cpu_rdata == $past(cfg_q))
    else $error("link config reads back wrong");
  a_tx_clear_empty: assert property (s_cmd(2) ##2 s_stat_rd |=> cpu_rdata[3:2] == 2'h0)
    else $error("transmit FIFO not empty after clear");
  a_rx_clear_empty: assert property (s_cmd(3) ##2 s_stat_rd |=> cpu_rdata[5:4] == 2'h0)
    else $error("receive FIFO not empty after clear");
endmodule

/* File: sim/hdc_far_end.sv */
// Far-end model of the D-channel: bit slots, receive bits, captured transmit bits
`timescale 1ns/10ps
module hdc_far_end (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bench control
  input  wire logic        bp_flags,
  // Device side
  input  wire logic        line_tx_bit,
  input  wire logic        bp_tx_bit,
  output logic             bit_en,
  output logic             line_rx_bit,
  output logic             bp_rx_bit,
  // Captured transmit bits
  output logic      [31:0] line_hist,
  output logic      [31:0] bp_hist,
  output logic      [15:0] line_zeros
);
  logic [1:0] div_q;
  logic [2:0] ph_q;
  logic       cap_q;

  // Line stays in the marking state; only the backplane carries flags
  assign line_rx_bit = 1'b1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q      <= 2'h0;
      ph_q       <= 3'h0;
      cap_q      <= 1'b0;
      bit_en     <= 1'b0;
      bp_rx_bit  <= 1'b1;
      line_hist  <= 32'h0;
      bp_hist    <= 32'h0;
      line_zeros <= 16'h0;
    end
    else
    begin
      div_q  <= div_q + 2'h1;
      bit_en <= (div_q == 2'h3);
      cap_q  <= bit_en;
      // New bit only after the device took the old one
      if (bit_en)
      begin
        ph_q      <= ph_q + 3'h1;
        bp_rx_bit <= !bp_flags || (ph_q != 3'h0 && ph_q != 3'h7);
      end
      if (cap_q)
      begin
        line_hist  <= {line_hist[30:0], line_tx_bit};
        bp_hist    <= {bp_hist[30:0], bp_tx_bit};
        line_zeros <= line_zeros + {15'h0, !line_tx_bit};
      end
    end
  end
endmodule

/* File: sim/test_hdc_dchan.sv */
// Self-checking bench of the D-channel controller
`timescale 1ns/10ps
module test_hdc_dchan;
  logic        clk, rst, cpu_wr, cpu_rd, te_mode, collision, bit_en, irq;
  logic        line_rx_bit, bp_rx_bit, line_tx_bit, bp_tx_bit, bp_flags;
  logic [4:0]  cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata;
  logic [31:0] line_hist, bp_hist;
  logic [15:0] line_zeros, z;
  logic [7:0]  cv [3] = '{8'hFD, 8'h5C, 8'h00};
  int          err_count = 0;
  int          check_count = 0;

  hdc_dchan i_dut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .te_mode(te_mode),
    .collision(collision), .bit_en(bit_en), .line_rx_bit(line_rx_bit),
    .bp_rx_bit(bp_rx_bit), .line_tx_bit(line_tx_bit), .bp_tx_bit(bp_tx_bit), .irq(irq));
  hdc_far_end i_far (.clk(clk), .rst(rst), .bp_flags(bp_flags), .line_tx_bit(line_tx_bit),
    .bp_tx_bit(bp_tx_bit), .bit_en(bit_en), .line_rx_bit(line_rx_bit),
    .bp_rx_bit(bp_rx_bit), .line_hist(line_hist), .bp_hist(bp_hist),
    .line_zeros(line_zeros));

  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(posedge clk);
    #1;
    cpu_wr = 1'b0;
  endtask
  // Read, keep the masked bits, compare
  task automatic rdc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(posedge clk);
    #1;
    cpu_rd = 1'b0;
    chk(cpu_rdata & m, e);
  endtask
  task automatic slots(input int n);
    repeat (n * 4) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] flag_seen(input logic [31:0] h);
    flag_seen = 8'h00;
    for (int i = 0; i < 25; i++)
      if (h[i +: 8] == 8'h7E)
        flag_seen = 8'h01;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is about 1800 cycles
  initial
  begin
    #2000000;
    err_count++;
    final_report;
  end

  initial
  begin
    clk = 1'b0;
    {cpu_addr, cpu_wdata, cpu_wr, cpu_rd, te_mode, collision, bp_flags} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rdc(5'h02, 8'hFF, 8'h00);
    rdc(5'h03, 8'h3D, 8'h00);
    foreach (cv[i])
    begin
      wr(5'h02, cv[i]);
      rdc(5'h02, 8'hFF, cv[i]);
    end
    rdc(5'h05, 8'hFF, 8'h00);
    $display("test registers finished");
    wr(5'h02, 8'h10);
    slots(34);
    chk({7'h0, &line_hist}, 8'h01);
    wr(5'h02, 8'h94);
    slots(34);
    chk(flag_seen(line_hist), 8'h01);
    chk({7'h0, &bp_hist}, 8'h01);
    wr(5'h02, 8'h84);
    slots(34);
    chk(flag_seen(bp_hist), 8'h01);
    chk({7'h0, &line_hist}, 8'h01);
    wr(5'h02, 8'h90);
    // Byte in flight finishes on the newly selected port first
    slots(44);
    chk({7'h0, &line_hist}, 8'h01);
    $display("test transmit ports finished");
    bp_flags = 1'b1;
    wr(5'h02, 8'h48);
    slots(20);
    rdc(5'h03, 8'h02, 8'h02);
    wr(5'h02, 8'h40);
    slots(20);
    rdc(5'h03, 8'h02, 8'h00);
    wr(5'h02, 8'h00);
    slots(20);
    rdc(5'h03, 8'h02, 8'h02);
    bp_flags = 1'b0;
    $display("test receive ports finished");
    rdc(5'h04, 8'h50, 8'h50);
    wr(5'h04, 8'h40);
    wr(5'h02, 8'hD9);
    slots(10);
    z = line_zeros;
    wr(5'h00, 8'hA1);
    wr(5'h00, 8'hB2);
    wr(5'h03, 8'h01);
    wr(5'h00, 8'hC3);
    slots(120);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, line_zeros != z}, 8'h01);
    rdc(5'h03, 8'hC1, 8'h41);
    rdc(5'h01, 8'hFF, 8'hA1);
    rdc(5'h03, 8'hC0, 8'h00);
    rdc(5'h01, 8'hFF, 8'hB2);
    rdc(5'h04, 8'h60, 8'h60);
    rdc(5'h04, 8'h60, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test loopback frame finished");
    wr(5'h04, 8'h14);
    wr(5'h03, 8'h02);
    wr(5'h00, 8'h55);
    slots(40);
    rdc(5'h04, 8'h10, 8'h10);
    wr(5'h00, 8'h66);
    slots(40);
    rdc(5'h04, 8'h04, 8'h04);
    $display("test abort and underrun finished");
    wr(5'h02, 8'h00);
    for (int i = 0; i < 20; i++)
    begin
      wr(5'h00, 8'(i));
      if (i == 3)
        rdc(5'h03, 8'h0C, 8'h04);
    end
    rdc(5'h03, 8'h0C, 8'h0C);
    wr(5'h03, 8'h04);
    rdc(5'h03, 8'h0C, 8'h00);
    wr(5'h03, 8'h08);
    rdc(5'h03, 8'h30, 8'h00);
    $display("test fifo clear finished");
    wr(5'h02, 8'h80);
    wr(5'h04, 8'h80);
    collision = 1'b1;
    slots(2);
    chk({7'h0, irq}, 8'h00);
    te_mode = 1'b1;
    slots(2);
    chk({7'h0, irq}, 8'h01);
    collision = 1'b0;
    rdc(5'h04, 8'h80, 8'h80);
    rdc(5'h04, 8'h80, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test collision finished");
    final_report;
  end
endmodule

bind hdc_dchan hdc_dchan_asserts i_chk (.clk(clk), .rst(rst), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .te_mode(te_mode), .bit_en(bit_en), .line_tx_bit(line_tx_bit), .bp_tx_bit(bp_tx_bit),
  .irq(irq));
